// [sbt_tap.sv]
// Boundary-scan test access port of the burst SRAM
// Summary of operation
// R1: Extest drives output cells to pins, input cells capture pin levels.
// R2: Extest at update-IR enables drivers with previously preloaded data.
// R3: Controller preloads the first vector before selecting extest.
// R4: Idcode loads fixed ID in capture-DR, shifts it in shift-DR.
// R5: Instruction is idcode after power-up and in test-logic-reset.
// R6: Bypass puts one-stage register between serial in and out.
// R7: Sample/preload captures input and data pins, then shifts them.
// R8: System keeps RAM inputs stable around the capture edge.
// R9: TAP runs independent of RAM clocks.
// R10: Tristate-sample floats data pins and shifts the boundary register.
// R11: Tristate-sample captures pad values while data pins float.
// R12: Codes 000,001,010,100,111 decoded; 011,101,110 reserved.
// R13: Undriven serial input and mode select act as logic 1.
// R14: Controller holds test clock low when the port is unused.
// R15: Sixteen-state controller on test clock rise, data out on fall.
// R16: Serial output driven only in shift-IR and shift-DR.
`timescale 1ns/1ps
module sbt_tap #(
    parameter int DQ_W = sbt_pkg::DQ_W,
    parameter int IN_W = sbt_pkg::IN_W,
    parameter int FIFO_DEPTH = sbt_pkg::FIFO_DEPTH,
    // Arbitrary identification value; bit 0 kept at 1
    parameter logic [31:0] ID_VALUE = 32'h0000_0001
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    output logic o_tdo,
    output logic o_tdo_oe,
    input wire logic [IN_W-1:0] i_pad_in,
    input wire logic [DQ_W-1:0] i_dq_in,
    input wire logic [DQ_W-1:0] i_core_dq_out,
    input wire logic [DQ_W-1:0] i_core_dq_oe,
    input wire logic i_pad_hold,
    output logic [DQ_W-1:0] o_dq_out,
    output logic [DQ_W-1:0] o_dq_oe
);
    localparam int BW = DQ_W + IN_W;
    localparam int SN = sbt_pkg::SYNC_N;

    // =====================================================
    // Test clock domain: reset synchroniser
    logic [SN-1:0] rst_ch;
    logic tck_rst_n;

    // The release is taken once the last two stages agree
    always_ff @(posedge i_tck) begin
        rst_ch <= {rst_ch[SN-2:0], i_rst_n};
    end

    always_ff @(posedge i_tck) begin
        if (rst_ch[SN-2] == rst_ch[SN-1]) tck_rst_n <= rst_ch[SN-1];
    end

    // =====================================================
    // TAP controller
    sbt_pkg::sbt_tap_e tap;
    sbt_pkg::sbt_tap_e next_tap;

    // Standard sixteen-state walk steered by mode select
    always_comb begin
        next_tap = tap;
        case (tap) // R15
            sbt_pkg::TAP_RESET:
                next_tap = i_tms ? sbt_pkg::TAP_RESET : sbt_pkg::TAP_IDLE;
            sbt_pkg::TAP_IDLE:
                next_tap = i_tms ? sbt_pkg::TAP_SEL_DR : sbt_pkg::TAP_IDLE;
            sbt_pkg::TAP_SEL_DR:
                next_tap = i_tms ? sbt_pkg::TAP_SEL_IR : sbt_pkg::TAP_CAP_DR;
            sbt_pkg::TAP_CAP_DR, sbt_pkg::TAP_SH_DR:
                next_tap = i_tms ? sbt_pkg::TAP_EX1_DR : sbt_pkg::TAP_SH_DR;
            sbt_pkg::TAP_EX1_DR:
                next_tap = i_tms ? sbt_pkg::TAP_UPD_DR : sbt_pkg::TAP_PAUSE_DR;
            sbt_pkg::TAP_PAUSE_DR:
                next_tap = i_tms ? sbt_pkg::TAP_EX2_DR : sbt_pkg::TAP_PAUSE_DR;
            sbt_pkg::TAP_EX2_DR:
                next_tap = i_tms ? sbt_pkg::TAP_UPD_DR : sbt_pkg::TAP_SH_DR;
            sbt_pkg::TAP_UPD_DR, sbt_pkg::TAP_UPD_IR:
                next_tap = i_tms ? sbt_pkg::TAP_SEL_DR : sbt_pkg::TAP_IDLE;
            sbt_pkg::TAP_SEL_IR:
                next_tap = i_tms ? sbt_pkg::TAP_RESET : sbt_pkg::TAP_CAP_IR;
            sbt_pkg::TAP_CAP_IR, sbt_pkg::TAP_SH_IR:
                next_tap = i_tms ? sbt_pkg::TAP_EX1_IR : sbt_pkg::TAP_SH_IR;
            sbt_pkg::TAP_EX1_IR:
                next_tap = i_tms ? sbt_pkg::TAP_UPD_IR : sbt_pkg::TAP_PAUSE_IR;
            sbt_pkg::TAP_PAUSE_IR:
                next_tap = i_tms ? sbt_pkg::TAP_EX2_IR : sbt_pkg::TAP_PAUSE_IR;
            sbt_pkg::TAP_EX2_IR:
                next_tap = i_tms ? sbt_pkg::TAP_UPD_IR : sbt_pkg::TAP_SH_IR;
            default:
                next_tap = sbt_pkg::TAP_RESET;
        endcase
    end

    // Pad pull-ups make a floating mode select read high, so a
    // loose pin parks the controller in reset
    always_ff @(posedge i_tck) begin
        if (!tck_rst_n) tap <= sbt_pkg::TAP_RESET;
        else tap <= next_tap; // R13
    end

    // =====================================================
    // Instruction register and decode
    logic [sbt_pkg::IR_W-1:0] ir_sh;
    logic [sbt_pkg::IR_W-1:0] ir;
    logic sel_ext;
    logic sel_id;
    logic sel_hz;
    logic sel_smp;
    logic sel_byp;
    logic sel_bsr;
    logic in_shift;

    // Reserved codes fall back to the bypass path
    assign sel_ext = (ir == sbt_pkg::IR_EXTEST); // R12
    assign sel_id = (ir == sbt_pkg::IR_IDCODE); // R12
    assign sel_hz = (ir == sbt_pkg::IR_SAMPZ); // R12
    assign sel_smp = (ir == sbt_pkg::IR_SAMPLE); // R12
    assign sel_byp = !(sel_ext || sel_id || sel_hz || sel_smp); // R12
    assign sel_bsr = sel_ext || sel_hz || sel_smp;
    assign in_shift = (tap == sbt_pkg::TAP_SH_DR) ||
                      (tap == sbt_pkg::TAP_SH_IR);

    // Shift stage enters at the top bit, leaves at the bottom bit
    always_ff @(posedge i_tck) begin
        if (tap == sbt_pkg::TAP_CAP_IR) begin
            ir_sh <= sbt_pkg::IR_CAPTURE;
        end else if (tap == sbt_pkg::TAP_SH_IR) begin
            ir_sh <= {i_tdi, ir_sh[sbt_pkg::INSTR_BIT_MSB:1]};
        end
    end

    // Active instruction changes only at update-IR, and reloads idcode in test-logic-reset
    always_ff @(posedge i_tck) begin
        if (!tck_rst_n || tap == sbt_pkg::TAP_RESET) begin
            ir <= sbt_pkg::IR_RESET; // R5
        end else if (tap == sbt_pkg::TAP_UPD_IR) begin
            ir <= ir_sh; // R2
        end
    end

    // =====================================================
    // Data registers: boundary, identification, bypass
    logic [BW-1:0] bsr;
    logic [sbt_pkg::ID_W-1:0] id_sh;
    logic byp;
    logic [DQ_W-1:0] upd;
    logic cap_dr;
    logic sh_dr;

    assign cap_dr = (tap == sbt_pkg::TAP_CAP_DR);
    assign sh_dr = (tap == sbt_pkg::TAP_SH_DR);

    // Pins are captured raw: the system must hold them steady
    // across this edge, else the sample is not repeatable
    always_ff @(posedge i_tck) begin
        if (cap_dr && sel_bsr) bsr <= {i_dq_in, i_pad_in}; // R1 R7 R11
        else if (sh_dr && sel_bsr) bsr <= {i_tdi, bsr[BW-1:1]}; // R7 R10
    end

    // Identification value loads on capture, then shifts out
    always_ff @(posedge i_tck) begin
        if (cap_dr && sel_id) id_sh <= ID_VALUE; // R4
        else if (sh_dr && sel_id) id_sh <= {i_tdi, id_sh[31:1]}; // R4
    end

    // One-stage bypass cell; captures zero as usual
    always_ff @(posedge i_tck) begin
        if (cap_dr && sel_byp) byp <= 1'b0; // R6
        else if (sh_dr && sel_byp) byp <= i_tdi; // R6
    end

    // Update latch holds the vector for the data-pin cells
    always_ff @(posedge i_tck) begin
        if (!tck_rst_n) upd <= '0;
        else if (tap == sbt_pkg::TAP_UPD_DR && sel_bsr) begin
            upd <= bsr[BW-1:IN_W]; // R1
        end
    end

    // =====================================================
    // Serial output, launched on the falling edge
    logic next_tdo;

    assign next_tdo = (tap == sbt_pkg::TAP_SH_IR) ?
                      ir_sh[sbt_pkg::INSTR_BIT_LSB] :
                      sel_id ? id_sh[0] : sel_bsr ? bsr[0] : byp;

    // Driven only while shifting; floats in every other state
    always_ff @(negedge i_tck) begin
        if (!tck_rst_n) begin
            o_tdo <= 1'b0;
            o_tdo_oe <= 1'b0;
        end else begin
            o_tdo <= next_tdo; // R15
            o_tdo_oe <= in_shift; // R16
        end
    end

    // =====================================================
    // Hand-off of vectors and modes to the RAM clock
    // The test clock owns all scan work; the RAM clock only
    // carries the finished vector and mode to the pin drivers
    logic req_t;
    logic pend;
    logic [DQ_W-1:0] xdat;
    logic ext_lvl;
    logic hz_lvl;
    logic [SN-1:0] ack_ch;
    logic ack_t;
    logic ack_m;
    logic busy;
    logic upd_ev;

    assign busy = (req_t != ack_t);
    assign upd_ev = (tap == sbt_pkg::TAP_UPD_DR) && sel_bsr;

    // Latest vector wins; one word is in flight at a time.
    // A new update in the launch cycle keeps pend set, so it is not lost
    always_ff @(posedge i_tck) begin
        if (!tck_rst_n) begin
            pend <= 1'b0;
            req_t <= 1'b0;
            xdat <= '0;
        end else begin
            pend <= upd_ev || (pend && busy);
            if (!busy && pend) begin
                req_t <= !req_t; // R9
                xdat <= upd;
            end
        end
    end

    // Mode levels held in flops so the crossing sees no glitch
    always_ff @(posedge i_tck) begin
        if (!tck_rst_n) begin
            ext_lvl <= 1'b0;
            hz_lvl <= 1'b0;
        end else begin
            ext_lvl <= sel_ext; // R2
            hz_lvl <= sel_hz; // R10
        end
    end

    // Acknowledge back into the test clock domain
    always_ff @(posedge i_tck) begin
        ack_ch <= {ack_ch[SN-2:0], ack_m};
    end

    always_ff @(posedge i_tck) begin
        if (!tck_rst_n) ack_t <= 1'b0;
        else if (ack_ch[SN-2] == ack_ch[SN-1]) ack_t <= ack_ch[SN-1];
    end

    // =====================================================
    // RAM clock domain: synchronise request and modes
    localparam int NL = 3;
    logic [NL-1:0] lvl_t;
    logic [NL-1:0] lvl_m;

    assign lvl_t = {hz_lvl, ext_lvl, req_t};

    for (genvar g = 0; g < NL; g++) begin : g_sync
        logic [SN-1:0] ch;
        always_ff @(posedge i_mclk) begin
            ch <= {ch[SN-2:0], lvl_t[g]};
        end
        always_ff @(posedge i_mclk) begin
            if (!i_rst_n) lvl_m[g] <= 1'b0;
            else if (ch[SN-2] == ch[SN-1]) lvl_m[g] <= ch[SN-1];
        end
    end

    // =====================================================
    // Vector FIFO and pin drivers
    logic wr_valid;
    logic wr_ready;
    logic rd_valid;
    logic rd_ready;
    logic [DQ_W-1:0] rd_data;
    logic [DQ_W-1:0] vec;
    logic ext_m;
    logic hz_m;
    logic [DQ_W-1:0] next_dq_out;
    logic [DQ_W-1:0] next_dq_oe;

    // A full FIFO withholds the ack, which stalls the next launch
    assign wr_valid = (lvl_m[0] != ack_m);
    assign rd_ready = !i_pad_hold;
    assign ext_m = lvl_m[1];
    assign hz_m = lvl_m[2];

    sbt_fifo #(
        .W(DQ_W),
        .D(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_wr_valid(wr_valid),
        .o_wr_ready(wr_ready),
        .i_wr_data(xdat),
        .o_rd_valid(rd_valid),
        .i_rd_ready(rd_ready),
        .o_rd_data(rd_data)
    );

    // Accept the word; xdat is stable until this ack returns
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) ack_m <= 1'b0;
        else if (wr_valid && wr_ready) ack_m <= lvl_m[0];
    end

    // Applied vector; the core may hold the drain off
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) vec <= '0;
        else if (rd_valid && rd_ready) vec <= rd_data;
    end

    // Extest overrides the core; tristate-sample floats the pins
    assign next_dq_out = ext_m ? vec : i_core_dq_out; // R1 R2
    assign next_dq_oe = ext_m ? {DQ_W{1'b1}} : // R2
                        hz_m ? {DQ_W{1'b0}} : i_core_dq_oe; // R10 R11

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_dq_out <= '0;
            o_dq_oe <= '0;
        end else begin
            o_dq_out <= next_dq_out;
            o_dq_oe <= next_dq_oe;
        end
    end

    // =====================================================
    // Checks in the test clock domain
    sequence tms_high_s;
        i_tms [*5];
    endsequence

    sequence id_cap_s;
        cap_dr && sel_id;
    endsequence

    sequence bsr_cap_s;
        cap_dr && sel_bsr;
    endsequence

    tlr_ir_a: assert property (@(posedge i_tck) // R5
        disable iff (!tck_rst_n)
        tap == sbt_pkg::TAP_RESET |=> ir == sbt_pkg::IR_IDCODE)
        else $error("instruction not idcode after reset state");

    tms_reset_a: assert property (@(posedge i_tck) // R15
        disable iff (!tck_rst_n)
        tms_high_s |=> tap == sbt_pkg::TAP_RESET)
        else $error("five high mode samples did not reach reset");

    id_load_a: assert property (@(posedge i_tck) // R4
        disable iff (!tck_rst_n)
        id_cap_s ##1 sh_dr |-> id_sh == ID_VALUE)
        else $error("id register not loaded at capture");

    bsr_cap_a: assert property (@(posedge i_tck) // R7
        disable iff (!tck_rst_n)
        bsr_cap_s |=> bsr == {$past(i_dq_in), $past(i_pad_in)})
        else $error("boundary capture missed pin levels");

    byp_path_a: assert property (@(posedge i_tck) // R6
        disable iff (!tck_rst_n)
        sh_dr && sel_byp ##1 sh_dr |-> next_tdo == $past(i_tdi))
        else $error("bypass stage not one bit long");

    // Held off until the test clock has clocked the reset in
    tdo_oe_a: assert property (@(posedge i_tck) // R16
        disable iff (!i_rst_n || !tck_rst_n)
        o_tdo_oe == in_shift)
        else $error("serial output driven outside shift");

    decode_a: assert property (@(posedge i_tck) // R12
        disable iff (!tck_rst_n)
        ir == 3'h3 || ir == 3'h5 || ir == 3'h6 |-> sel_byp && !sel_bsr)
        else $error("reserved code not decoded as bypass");

    // =====================================================
    // Checks in the RAM clock domain
    ext_drive_a: assert property (@(posedge i_mclk) // R2
        disable iff (!i_rst_n)
        ext_m |=> o_dq_oe == {DQ_W{1'b1}} && o_dq_out == $past(vec))
        else $error("extest did not drive the update vector");

    hz_float_a: assert property (@(posedge i_mclk) // R10
        disable iff (!i_rst_n)
        hz_m && !ext_m |=> o_dq_oe == '0)
        else $error("data pins not floated under tristate-sample");
endmodule : sbt_tap

// [sbt_pkg.sv]
// Shared constants and types for the SRAM boundary-scan test port
package sbt_pkg;
    // =====================================================
    // Instruction register
    localparam int IR_W = 3;
    localparam int INSTR_BIT_MSB = 2;
    localparam int INSTR_BIT_LSB = 0;
    localparam logic [2:0] IR_EXTEST = 3'h0;
    localparam logic [2:0] IR_IDCODE = 3'h1;
    localparam logic [2:0] IR_SAMPZ = 3'h2;
    localparam logic [2:0] IR_SAMPLE = 3'h4;
    localparam logic [2:0] IR_BYPASS = 3'h7;
    // Fixed pattern loaded in capture-IR, low bits 01 as usual
    localparam logic [2:0] IR_CAPTURE = 3'h1;
    // Reset value of the instruction register
    localparam logic [2:0] IR_RESET = IR_IDCODE;

    // =====================================================
    // Data registers and crossings
    localparam int ID_W = 32;
    localparam int DQ_W = 8;
    localparam int IN_W = 8;
    localparam int SYNC_N = 3;
    localparam int FIFO_DEPTH = 16;
    // Consecutive high mode-select samples that force the reset state
    localparam int TMS_RESET_N = 5;

    // =====================================================
    // TAP controller states
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE,
        TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
        TAP_PAUSE_DR, TAP_EX2_DR, TAP_UPD_DR,
        TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR,
        TAP_PAUSE_IR, TAP_EX2_IR, TAP_UPD_IR
    } sbt_tap_e;
endpackage : sbt_pkg

// [sbt_fifo.sv]
// Small synchronous FIFO with registered read data
`timescale 1ns/1ps
module sbt_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_wr_valid,
    output logic o_wr_ready,
    input wire logic [W-1:0] i_wr_data,
    output logic o_rd_valid,
    input wire logic i_rd_ready,
    output logic [W-1:0] o_rd_data
);
    // =====================================================
    // Storage and pointers; D must be a power of two
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic push;
    logic load;

    // Full when the array holds D words; output stage adds one more
    assign o_wr_ready = (cnt != (AW+1)'(D));
    assign push = i_wr_valid && o_wr_ready;
    assign load = (cnt != '0) && (!o_rd_valid || i_rd_ready);

    // Write side
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wp] <= i_wr_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            if (push) wp <= wp + 1'b1;
            if (load) rp <= rp + 1'b1;
            cnt <= cnt + (AW+1)'(push) - (AW+1)'(load);
        end
    end

    // Registered read stage; stalls while the reader holds off
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rd_valid <= 1'b0;
            o_rd_data <= '0;
        end else if (load) begin
            o_rd_valid <= 1'b1;
            o_rd_data <= mem[rp];
        end else if (i_rd_ready) begin
            o_rd_valid <= 1'b0;
        end
    end
endmodule : sbt_fifo

// [sbt_jtag_ctl.sv]
// Behavioural boundary-scan test controller facing the test port
`timescale 1ns/1ps
module sbt_jtag_ctl (
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi,
    input wire logic i_tdo,
    input wire logic i_tdo_oe
);
    // Enable seen at the rise, and its product over the last shift
    logic oe_rise;
    logic oe_all;
    // Extra low time per tick, to act as a slow controller
    int gap_ns;

    // =====================================================
    // Clock rests low between frames; idle lines rest at the pull-up
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b1;
        oe_all = 1'b1;
        oe_rise = 1'b0;
        gap_ns = 0;
    end

    // =====================================================
    // One 64 ns period plus gap_ns; lines set well before the rise, data out read at it
    task automatic tick(input logic tms, input logic tdi, output logic tdo);
        o_tms = tms;
        o_tdi = tdi;
        #16;
        o_tck = 1'b1;
        tdo = i_tdo;
        oe_rise = i_tdo_oe;
        #32;
        o_tck = 1'b0;
        #16;
        o_tdi = 1'b1;
        #(gap_ns);
    endtask : tick

    // Idle ticks, needed for launches that wait on the test clock
    task automatic idle(input int n);
        logic d;
        repeat (n) tick(1'b0, 1'b1, d);
    endtask : idle

    // Five or more high mode-select samples, then park in idle
    task automatic tap_reset();
        logic d;
        repeat (6) tick(1'b1, 1'b1, d);
        tick(1'b0, 1'b1, d);
    endtask : tap_reset

    // Full IR or DR scan from idle back to idle, LSB first
    task automatic scan(input bit ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic d;
        int i;
        dout = '0;
        oe_all = 1'b1;
        tick(1'b1, 1'b1, d);
        if (ir) tick(1'b1, 1'b1, d);
        tick(1'b0, 1'b1, d);
        tick(1'b0, 1'b1, d);
        for (i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], d);
            dout[i] = d;
            oe_all = oe_all & oe_rise;
        end
        tick(1'b1, 1'b1, d);
        idle(2);
    endtask : scan
endmodule : sbt_jtag_ctl

// [sbt_tap_tb_top.sv]
// Self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
module sbt_tap_tb_top;
    // Arbitrary identification value, bit 0 kept at 1
    localparam logic [31:0] ID_VAL = 32'h1234_5679;
    logic mclk, rst_n, tck, tms, tdi, tdo, tdo_oe, pad_hold;
    logic [7:0] pad_in, dq_in, core_out, core_oe, dq_out, dq_oe;
    logic [31:0] d;
    int fails = 0;
    int tests_run = 0;

    // =====================================================
    // Device and controller
    sbt_tap #(.ID_VALUE(ID_VAL)) dut (.i_mclk(mclk), .i_rst_n(rst_n),
        .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo),
        .o_tdo_oe(tdo_oe), .i_pad_in(pad_in), .i_dq_in(dq_in),
        .i_core_dq_out(core_out), .i_core_dq_oe(core_oe),
        .i_pad_hold(pad_hold), .o_dq_out(dq_out), .o_dq_oe(dq_oe));
    sbt_jtag_ctl ctl (.o_tck(tck), .o_tms(tms), .o_tdi(tdi),
        .i_tdo(tdo), .i_tdo_oe(tdo_oe));

    // Main clock, 100 ns
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // =====================================================
    // Verdict and comparison
    task automatic wrap_up();
        if (fails == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Pins lag the test clock by a crossing, so poll under a bound
    task automatic wait_pins(input logic [7:0] oe, input logic [7:0] out,
                             input bit use_out);
        int n;
        n = 0;
        while ((dq_oe !== oe || (use_out && dq_out !== out)) && n < 60) begin
            @(negedge mclk);
            n++;
        end
        if (n == 60) begin
            fails++;
            $display("mismatch at %0t: pins did not settle", $time);
            wrap_up();
        end
    endtask : wait_pins

    // Load an instruction; the captured pattern comes out meanwhile
    task automatic load_ir(input logic [2:0] code);
        ctl.scan(1'b1, 3, {29'h0, code}, d);
        check(d, {29'h0, sbt_pkg::IR_CAPTURE});
    endtask : load_ir

    // =====================================================
    // Scenarios
    task automatic s_reset_id();
        check(tdo_oe, 1'b0);
        ctl.scan(1'b0, 32, 32'h0, d);
        check(d, ID_VAL);
        check(ctl.oe_all, 1'b1);
        check(tdo_oe, 1'b0);
        @(negedge mclk);
        core_out = 8'h3c;
        core_oe = 8'h0f;
        wait_pins(8'h0f, 8'h3c, 1'b1);
        check({dq_oe, dq_out}, 16'h0f3c);
    endtask : s_reset_id

    task automatic s_bypass();
        logic [2:0] codes [4] = '{3'h7, 3'h3, 3'h5, 3'h6};
        foreach (codes[k]) begin
            load_ir(codes[k]);
            ctl.scan(1'b0, 8, 32'ha5, d);
            check(d, 32'h4a);
        end
    endtask : s_bypass

    // Pads held stable across the capture edge
    task automatic s_sample();
        @(negedge mclk);
        pad_in = 8'h96;
        dq_in = 8'h3e;
        load_ir(sbt_pkg::IR_SAMPLE);
        ctl.scan(1'b0, 16, 32'hc500, d);
        check(d, 32'h3e96);
        check({dq_oe, dq_out}, 16'h0f3c);
    endtask : s_sample

    task automatic s_extest();
        int k;
        load_ir(sbt_pkg::IR_EXTEST);
        wait_pins(8'hff, 8'hc5, 1'b1);
        check({dq_oe, dq_out}, 16'hffc5);
        @(negedge mclk);
        pad_in = 8'h69;
        ctl.scan(1'b0, 16, 32'h5b00, d);
        check(d[7:0], 8'h69);
        wait_pins(8'hff, 8'h5b, 1'b1);
        check(dq_out, 8'h5b);
        // Seventeen vectors fill the buffer and its output stage while
        // the pins stall; the eighteenth must wait for the drain
        @(negedge mclk);
        pad_hold = 1'b1;
        ctl.gap_ns = 200;
        for (k = 0; k < 18; k++) begin
            ctl.scan(1'b0, 16, {16'h0, 8'h10 + 8'(k), 8'h00}, d);
        end
        ctl.gap_ns = 0;
        check(dq_out, 8'h5b);
        @(negedge mclk);
        pad_hold = 1'b0;
        ctl.idle(20);
        wait_pins(8'hff, 8'h21, 1'b1);
        check(dq_out, 8'h21);
    endtask : s_extest

    task automatic s_samplez();
        load_ir(sbt_pkg::IR_SAMPZ);
        wait_pins(8'h00, 8'h00, 1'b0);
        check(dq_oe, 8'h00);
        @(negedge mclk);
        pad_in = 8'hc3;
        dq_in = 8'h81;
        ctl.scan(1'b0, 16, 32'h0, d);
        check(d, 32'h81c3);
    endtask : s_samplez

    task automatic s_tlr();
        load_ir(sbt_pkg::IR_BYPASS);
        ctl.tap_reset();
        ctl.scan(1'b0, 32, 32'h0, d);
        check(d, ID_VAL);
        wait_pins(8'h0f, 8'h3c, 1'b1);
        check({dq_oe, dq_out}, 16'h0f3c);
    endtask : s_tlr

    // =====================================================
    // Reset with the test clock running, then the scenarios
    initial begin
        rst_n = 1'b0;
        pad_in = 8'h00;
        dq_in = 8'h00;
        core_out = 8'h00;
        core_oe = 8'h00;
        pad_hold = 1'b0;
        fork
            repeat (16) @(negedge mclk);
            ctl.tap_reset();
        join
        @(negedge mclk);
        rst_n = 1'b1;
        ctl.tap_reset();
        s_reset_id();
        s_bypass();
        s_sample();
        s_extest();
        s_samplez();
        s_tlr();
        wrap_up();
    end
endmodule : sbt_tap_tb_top
